// file: bench/port_chk_asserts.sv
// Checker for the sensor drive port bus handshake and pads.
`timescale 1ns/1ns
module port_chk
#(
	parameter PINS = 2
)
(
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	input wire [31:0] dat_o,
	input wire [PINS-1:0] sensor_drive_pin_o,
	input wire [PINS-1:0] sensor_drive_pin_oe_o,
	input wire reference_output_on_pin0_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_resp_a: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o) else $error("no ack");
	ack_once_a: assert property (ack_o |=> !ack_o) else $error("long ack");
	ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
	read_high_a: assert property (dat_o[31:8] == 24'h0) else $error("high bits");
	reset_pad_a: assert property ($fell(rst_i) |-> ##[0:1]
		{sensor_drive_pin_oe_o, sensor_drive_pin_o} == 4'hc) else $error("pad reset");
	ref_off_a: assert property (reference_output_on_pin0_o [*2] |->
		!sensor_drive_pin_oe_o[0]) else $error("bypass drive");
	oe_cause_a: assert property ($changed(sensor_drive_pin_oe_o) |->
		$past(ack_o) || $past(rst_i, 2)) else $error("oe change");
	drive_cause_a: assert property ($changed(sensor_drive_pin_o) |->
		$past(ack_o) || $past(rst_i, 2)) else $error("drive change");
endmodule // port_chk
bind sensor_drive_port port_chk #(.PINS(PINS)) u_port_chk (.*);

// file: bench/sensor_drive_port_bench.sv
// Register bench for the sensor drive port.
`timescale 1ns/1ns
module sensor_drive_port_bench;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, ack_o;
	logic [7:0] adr_i = 8'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic [1:0] sensor_drive_pin_i, sensor_drive_pin_o, sensor_drive_pin_oe_o, ext = 2'h2;
	logic reference_output_on_pin0_o, reference_input_on_pin1_o;
	int failures = 0, n_tests = 0;
	sensor_drive_port u_sensor_drive_port (.*, .ce_i(1'h1), .sel_i(4'hf));
	sensor_elem u_sensor_elem (.drv_i(sensor_drive_pin_o), .oe_i(sensor_drive_pin_oe_o),
		.ext_i(ext), .pad_o(sensor_drive_pin_i));
	initial forever #25 clk_i = ~clk_i;
	task wb(input logic w, input logic [7:0] a, d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, 24'h0, d};
		@(posedge clk_i);
		while (ack_o !== 1'h1) @(posedge clk_i);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'h0;
	endtask
	task chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h0, 8'h40, 8'h0);
		chk(rd, 32'h30);
		chk({sensor_drive_pin_oe_o, sensor_drive_pin_o}, 32'hc);
		wb(1'h0, 8'h41, 8'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		wb(1'h1, 8'h40, 8'h11);
		wb(1'h0, 8'h41, 8'h0);
		chk(rd, 32'h3);
		chk({sensor_drive_pin_oe_o, sensor_drive_pin_o}, 32'h5);
		wb(1'h0, 8'h40, 8'h0);
		chk(rd, 32'h11);
		$display("direction test done");
		wb(1'h1, 8'h70, 8'hff);
		wb(1'h0, 8'h70, 8'h0);
		chk(rd, 32'h3);
		chk({reference_output_on_pin0_o, reference_input_on_pin1_o}, 32'h3);
		chk(sensor_drive_pin_oe_o, 32'h0);
		wb(1'h0, 8'h41, 8'h0);
		chk(rd, 32'h2);
		wb(1'h0, 8'h55, 8'h0);
		chk(rd, 32'h0);
		$display("mode test done");
		close_out;
	end
	initial
	begin
		repeat (2000) @(posedge clk_i);
		failures++;
		close_out;
	end
endmodule // sensor_drive_port_bench

// file: bench/sensor_elem.sv
// Sensing elements that hold the pads wherever the port lets go.
`timescale 1ns/1ns
module sensor_elem
(
	// Pad controls and the sensor's own level
	input wire [1:0] drv_i,
	input wire [1:0] oe_i,
	input wire [1:0] ext_i,
	// Resolved pad level
	output wire [1:0] pad_o
);
	assign pad_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule // sensor_elem

// file: logic/pin_cell.v
// One sensor drive pin: direction, data and reference bypass to pad controls.
`timescale 1ns/1ns
module pin_cell
(
	// Clock, reset and enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Control
	input wire dir_i,
	input wire data_i,
	input wire bypass_i,
	// Pad
	input wire pad_i,
	output reg pad_o,
	output reg pad_oe_o,
	output reg level_o
);
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pad_o <= 1'b0;
			pad_oe_o <= 1'b0;
			level_o <= 1'b0;
		end
		else if (ce_i)
		begin
			// A bypassed pin carries the analog reference, so the digital driver must let go.
			pad_oe_o <= dir_i & ~bypass_i;
			pad_o <= data_i & dir_i & ~bypass_i;
			// The input path stays on even while driving, so the real pad level reads back.
			level_o <= pad_i;
		end
	end
endmodule // pin_cell

// file: logic/sensor_drive_port.v
// Two-bit sensor drive port with a classic Wishbone register slave.
//
// Behaviour
// - Each pin has its own direction bit.
// - Direction one keeps input and driver active.
// - Direction zero makes the pin input only.
// - Reset sets all direction bits to one.
// - Input register shows pin levels, no debounce.
// - Input path stays active while driving.
// - Output data bits drive pins when direction one.
// - Reset clears output data bits to zero.
// - Mode reference bits hand pins to reference.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
`include "sensor_port_map.vh"
module sensor_drive_port
#(
	parameter PINS = 2
)
(
	// Clock, reset and enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// Sensor drive pins
	input wire [PINS-1:0] sensor_drive_pin_i,
	output wire [PINS-1:0] sensor_drive_pin_o,
	output wire [PINS-1:0] sensor_drive_pin_oe_o,
	// Reference hand-over, high while a pin carries the reference
	output reg reference_output_on_pin0_o,
	output reg reference_input_on_pin1_o
);
	reg [PINS-1:0] out_data;
	reg [PINS-1:0] out_dir;
	reg [7:0] operating_mode;
	wire [PINS-1:0] level;
	wire [PINS-1:0] bypass;
	wire [7:0] pin_output_register;
	wire [7:0] pin_input_register;
	wire req;
	reg [7:0] next_rdata;

	assign req = cyc_i & stb_i & ~ack_o;
	assign bypass = operating_mode[PINS-1:0];
	// Only bits 1:0 (data) and 5:4 (direction) of the output register exist; the rest read zero.
	assign pin_output_register = {2'h0, out_dir, 2'h0, out_data};
	assign pin_input_register = {6'h00, level};

	always @*
	begin
		next_rdata = `BYTE_ZERO;
		if (adr_i == `ADDR_PIN_OUTPUT)
			next_rdata = pin_output_register;
		else if (adr_i == `ADDR_PIN_INPUT)
			next_rdata = pin_input_register;
		else if (adr_i == `ADDR_OPERATING_MODE)
			next_rdata = operating_mode & `MODE_USED_MASK;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_data <= `RESET_DATA;
			out_dir <= `RESET_DIR;
			operating_mode <= `RESET_MODE;
			ack_o <= 1'b0;
			dat_o <= 32'h0;
			reference_output_on_pin0_o <= 1'b0;
			reference_input_on_pin1_o <= 1'b0;
		end
		else if (ce_i)
		begin
			ack_o <= req;
			// Unmapped addresses are acknowledged, read zero and ignore writes.
			if (req)
				dat_o <= {24'h0, next_rdata};
			if (req & we_i & sel_i[0])
			begin
				if (adr_i == `ADDR_PIN_OUTPUT)
				begin
					out_data <= dat_i[`DATA_LSB+PINS-1:`DATA_LSB];
					out_dir <= dat_i[`DIR_LSB+PINS-1:`DIR_LSB];
				end
				else if (adr_i == `ADDR_OPERATING_MODE)
					operating_mode <= dat_i[7:0] & `MODE_USED_MASK;
			end
			reference_output_on_pin0_o <= operating_mode[`MODE_REF_OUT_BIT];
			reference_input_on_pin1_o <= operating_mode[`MODE_REF_IN_BIT];
		end
	end

	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1)
		begin : pins
			pin_cell u_pin_cell
			(
				.clk_i(clk_i),
				.rst_i(rst_i),
				.ce_i(ce_i),
				.dir_i(out_dir[g]),
				.data_i(out_data[g]),
				.bypass_i(bypass[g]),
				.pad_i(sensor_drive_pin_i[g]),
				.pad_o(sensor_drive_pin_o[g]),
				.pad_oe_o(sensor_drive_pin_oe_o[g]),
				.level_o(level[g])
			);
		end
	endgenerate
endmodule // sensor_drive_port

// file: logic/sensor_port_map.vh
// Register offsets, field positions and reset values of the sensor drive port.
`ifndef SENSOR_PORT_MAP_VH
`define SENSOR_PORT_MAP_VH
`define ADDR_PIN_OUTPUT 8'h40
`define ADDR_PIN_INPUT 8'h41
`define ADDR_OPERATING_MODE 8'h70
`define DATA_LSB 0
`define DIR_LSB 4
`define MODE_REF_OUT_BIT 0
`define MODE_REF_IN_BIT 1
`define MODE_USED_MASK 8'h03
`define RESET_DATA 2'h0
`define RESET_DIR 2'h3
`define RESET_MODE 8'h00
`define BYTE_ZERO 8'h00
`endif
